// [core/ltb_pkg.sv]
// package: register map, field layout, enums and carriers of the limit-test binning block
package ltb_pkg;
    localparam int unsigned N_LIM = 11;   // tests 2..12
    localparam int unsigned AW    = 8;    // register address width

    // register byte offsets
    localparam logic [7:0] R_CTRL    = 8'h00;
    localparam logic [7:0] R_CMD     = 8'h04;
    localparam logic [7:0] R_OFFS    = 8'h08;
    localparam logic [7:0] R_LIMEN   = 8'h0C;
    localparam logic [7:0] R_FLAGS   = 8'h10;
    localparam logic [7:0] R_EVT     = 8'h14;
    localparam logic [7:0] R_LATEST  = 8'h18;
    localparam logic [7:0] R_GPAT    = 8'h1C;
    localparam logic [7:0] R_CMPPAT  = 8'h20;
    localparam logic [7:0] R_COUNT   = 8'h24;
    localparam logic [7:0] R_BUFDATA = 8'h28;
    localparam logic [7:0] R_BUFPTR  = 8'h2C;
    localparam logic [7:0] R_DEFPAT  = 8'h30;
    localparam logic [7:0] T_BASE    = 8'h40;  // 16 bytes per limit test
    localparam logic [1:0] T_LOW     = 2'h0;
    localparam logic [1:0] T_UPP     = 2'h1;
    localparam logic [1:0] T_FPAT    = 2'h2;
    localparam logic [1:0] T_PPAT    = 2'h3;

    // control, command and event register fields
    localparam int CF_FEED   = 0;
    localparam int CF_NULL   = 2;
    localparam int CF_SORT   = 3;
    localparam int CF_END    = 4;
    localparam int CF_AUTO   = 5;
    localparam int CF_OUTCMP = 6;
    localparam int CF_WID    = 7;
    localparam int CF_LIM1   = 9;
    localparam int CMD_CLR   = 0;
    localparam int CMD_ACQ   = 1;
    localparam int EVT_UPP   = 16;

    // pattern widths, reset values and bus response codes
    localparam logic [1:0]  WID_3   = 2'h0;
    localparam logic [1:0]  WID_16  = 2'h2;
    localparam logic [15:0] MASK_3  = 16'h0007;
    localparam logic [15:0] MASK_4  = 16'h000F;
    localparam logic [15:0] MASK_16 = 16'hFFFF;
    localparam logic [31:0] LOW_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] UPP_RST = 32'h0000_0001;
    localparam logic [1:0]  RESP_OK  = 2'h0;
    localparam logic [1:0]  RESP_ERR = 2'h2;

    typedef enum logic [1:0] {FEED_MATH, FEED_VOLT, FEED_CURR, FEED_RES} ltb_feed_e;

    typedef struct packed {
        logic [AW-1:0] awaddr;
        logic          awvalid;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          wvalid;
        logic          bready;
        logic [AW-1:0] araddr;
        logic          arvalid;
        logic          rready;
    } ltb_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ltb_axi_rsp_s;

    typedef struct packed {
        logic [31:0] mathRes;
        logic [31:0] volt;
        logic [31:0] curr;
        logic [31:0] res;
        logic        valid;
        logic        inCmp;
    } ltb_rdg_s;

    typedef struct packed {
        logic        valid;
        logic        inCmp;
        logic [31:0] raw;
        logic [31:0] calc;
    } ltb_feed_s;
endpackage

// [core/ltb_mem.sv]
// reading store: single write port, registered read port
`timescale 1ns/10ps
module ltb_mem #(
    parameter int W     = 32,
    parameter int DEPTH = 64
) (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst_b,
    // write side
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] wAddr,
    input  wire logic [W-1:0]             wData,
    // read side
    input  wire logic [$clog2(DEPTH)-1:0] rAddr,
    output logic      [W-1:0]             rData
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [W-1:0]            rd;
    } ltb_mem_s;

    ltb_mem_s s_q;
    ltb_mem_s s_d;

    if (DEPTH < 2) begin : g_chk
        $error("ltb_mem: DEPTH must be at least 2");
    end

    // write and registered read
    always_comb begin
        s_d = s_q;
        s_d.rd = s_q.mem[rAddr];
        if (we) begin
            s_d.mem[wAddr] = wData;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rData = s_q.rd;
endmodule

// [core/ltb_feed.sv]
// input path: source select and null offset subtraction
`timescale 1ns/10ps
module ltb_feed
    import ltb_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // raw readings and settings
    input  wire ltb_rdg_s    rdg,
    input  wire ltb_feed_e   feedSel,
    input  wire logic        nullEn,
    input  wire logic [31:0] nullOffset,
    // processed reading
    output ltb_feed_s        feed
);
    ltb_feed_s s_q;
    ltb_feed_s s_d;

    // pick the source, then subtract the offset when enabled
    always_comb begin
        s_d = s_q;
        s_d.valid = rdg.valid;
        if (rdg.valid) begin
            s_d.inCmp = rdg.inCmp;
            unique case (feedSel)
                FEED_MATH: s_d.raw = rdg.mathRes;
                FEED_VOLT: s_d.raw = rdg.volt;
                FEED_CURR: s_d.raw = rdg.curr;
                FEED_RES:  s_d.raw = rdg.res;
            endcase
            s_d.calc = nullEn ? s_d.raw - nullOffset : s_d.raw;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign feed = s_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_null_sub: assert property (rdg.valid && nullEn |=> s_q.calc == s_q.raw - $past(nullOffset))
        else $error("null offset not subtracted");
endmodule

// [core/ltb_core.sv]
// limit-test and binning core with its register slave
`timescale 1ns/10ps
// How it works
// - limit input comes from math result, voltage, current or resistance
// - with null on, reading minus signed offset; otherwise unchanged
// - acquire request stores the next reading as offset
// - compliance test fails while in or while out of compliance, per CF_OUTCMP
// - each limit test has signed lower/upper, reset -1 and 1
// - limits compare in plain reading units, no range scaling
// - order: compliance, then tests lower before upper, ascending
// - first failing check picks the pattern; later ones ignored
// - per-bound fail patterns only in grading; compliance in both
// - patterns are 3 or 4 bits; line 4 unused in 3-bit mode
// - bit 0 on line 1 up to bit 3 on line 4, one high
// - optional 16-bit port accepts 16-bit patterns
// - pattern drives at once or waits for end of testing
// - sorting: each test has its own pass pattern
// - disabled test is skipped; no flag, no pattern effect
// - any enabled test gives limits ownership of the output
// - one flag per test, 1 failed, bound not shown
// - reading flags keeps them; only a clear resets them
// - event register records lower versus upper failure
// - readings stored only while some test is enabled
// - latest reading readable beside the full store
// - grading: first failure pattern, else global pass pattern
// - sorting: compliance pattern, first passing band, else global fail, or global pass with no band enabled
// - immediate mode outputs first failure or pass at once
// - clear or auto-clear start resets flags and output level
module ltb_core
    import ltb_pkg::*;
#(
    parameter int OUT_W     = 16,
    parameter int BUF_DEPTH = 64
) (
    // clock and reset
    input  wire logic           clock,
    input  wire logic           rst_b,
    // register bus
    input  wire ltb_axi_req_s   axiReq,
    output ltb_axi_rsp_s        axiRsp,
    // readings and sequence events
    input  wire ltb_rdg_s       rdg,
    input  wire logic           seqStart,
    input  wire logic           seqEnd,
    // handler output lines
    output logic [OUT_W-1:0]    digOut
);
    localparam int CW = $clog2(BUF_DEPTH + 1);
    localparam int PW = $clog2(BUF_DEPTH);

    if ((OUT_W != 4 && OUT_W != 16) || BUF_DEPTH < 2) begin : g_chk
        $error("ltb_core: OUT_W must be 4 or 16 and BUF_DEPTH at least 2");
    end

    typedef struct packed {
        logic [31:0]            ctrl;
        logic [31:0]            offs;
        logic [N_LIM-1:0]       limEn;
        logic [31:0]            gPat;     // pass low half, fail high half
        logic [15:0]            cmpPat;
        logic [15:0]            defPat;
        logic [N_LIM-1:0][31:0] lowLim;
        logic [N_LIM-1:0][31:0] uppLim;
        logic [N_LIM-1:0][31:0] failPat;  // lower fail low half, upper fail high half
        logic [N_LIM-1:0][15:0] passPat;
        logic                   acqPend;
        logic [N_LIM:0]         failFlg;
        logic [31:0]            evt;
        logic [31:0]            latest;
        logic [15:0]            outPat;
        logic [15:0]            pendPat;
        logic                   pendV;
        logic [CW-1:0]          count;
        logic [PW-1:0]          bufPtr;
        logic                   awPend;
        logic                   wPend;
        logic [AW-1:0]          awAddr;
        logic [31:0]            wData;
        logic [3:0]             wStrb;
        logic                   bValid;
        logic [1:0]             bResp;
        logic                   arPend;
        logic [AW-1:0]          arAddr;
        logic                   rValid;
        logic [31:0]            rData;
        logic [1:0]             rResp;
    } ltb_state_s;

    typedef struct packed {
        logic [15:0]      pat;
        logic             anyFail;
        logic             cmpFail;
        logic [N_LIM-1:0] lowF;
        logic [N_LIM-1:0] uppF;
    } ltb_eval_s;

    localparam ltb_state_s S_RST = '{lowLim: {N_LIM{LOW_RST}}, uppLim: {N_LIM{UPP_RST}},
                                     default: '0};

    ltb_state_s  s_q;
    ltb_state_s  s_d;
    ltb_feed_s   feed;
    ltb_eval_s   ev;
    logic [31:0] memData;
    logic [15:0] curMask;
    logic        anyEn;
    logic        wrFire;
    logic        clrEv;
    logic        memWe;
    logic [PW-1:0] memAddr;

    // pattern width mask from the width mode
    function automatic logic [15:0] patMask(logic [1:0] w);
        if (w == WID_3) begin
            return MASK_3;
        end else if (w == WID_16 && OUT_W == 16) begin
            return MASK_16;
        end
        return MASK_4;
    endfunction

    // byte-lane merge for write strobes
    function automatic logic [31:0] wmerge(logic [31:0] old, logic [31:0] nw, logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // limit test slot decode
    function automatic logic tHit(logic [AW-1:0] a);
        return a >= T_BASE && 32'(a[7:4] - T_BASE[7:4]) < N_LIM;
    endfunction

    function automatic logic [3:0] tIdx(logic [AW-1:0] a);
        return a[7:4] - T_BASE[7:4];
    endfunction

    // register readback, also the base of strobed writes
    function automatic logic [31:0] regRead(ltb_state_s s, logic [AW-1:0] a, logic [31:0] md);
        logic [3:0] i;
        i = tIdx(a);
        unique case (a)
            R_CTRL:    return s.ctrl;
            R_CMD:     return 32'(s.acqPend) << CMD_ACQ;
            R_OFFS:    return s.offs;
            R_LIMEN:   return 32'(s.limEn);
            R_FLAGS:   return 32'(s.failFlg);
            R_EVT:     return s.evt;
            R_LATEST:  return s.latest;
            R_GPAT:    return s.gPat;
            R_CMPPAT:  return 32'(s.cmpPat);
            R_COUNT:   return 32'(s.count);
            R_BUFDATA: return md;
            R_BUFPTR:  return 32'(s.bufPtr);
            R_DEFPAT:  return 32'(s.defPat);
            default: begin
                if (!tHit(a)) begin
                    return '0;
                end
                unique case (a[3:2])
                    T_LOW:  return s.lowLim[i];
                    T_UPP:  return s.uppLim[i];
                    T_FPAT: return s.failPat[i];
                    T_PPAT: return 32'(s.passPat[i]);
                endcase
            end
        endcase
        return '0;
    endfunction

    function automatic logic mapped(logic [AW-1:0] a);
        return a <= R_DEFPAT || tHit(a);
    endfunction

    // compliance and band checks in test order, first decisive check wins
    function automatic ltb_eval_s evaluate(ltb_state_s s, ltb_feed_s f, logic [15:0] m);
        ltb_eval_s e;
        logic      found;
        e = '0;
        found = 1'b0;
        e.cmpFail = s.ctrl[CF_LIM1] & (s.ctrl[CF_OUTCMP] ? ~f.inCmp : f.inCmp);
        for (int i = 0; i < N_LIM; i++) begin
            // plain signed compare in reading units, inclusive bounds
            e.lowF[i] = s.limEn[i] & ($signed(f.calc) < $signed(s.lowLim[i]));
            e.uppF[i] = s.limEn[i] & ($signed(f.calc) > $signed(s.uppLim[i]));
        end
        e.anyFail = e.cmpFail | (|e.lowF) | (|e.uppF);
        if (e.cmpFail) begin
            e.pat = s.cmpPat;
            found = 1'b1;
        end
        if (!s.ctrl[CF_SORT]) begin
            if (!found) begin
                e.pat = s.gPat[15:0];
            end
            for (int i = 0; i < N_LIM; i++) begin
                if (!found && e.lowF[i]) begin
                    e.pat = s.failPat[i][15:0];
                    found = 1'b1;
                end else if (!found && e.uppF[i]) begin
                    e.pat = s.failPat[i][31:16];
                    found = 1'b1;
                end
            end
        end else begin
            if (!found) begin
                e.pat = (s.limEn == '0) ? s.gPat[15:0] : s.gPat[31:16];
            end
            for (int i = 0; i < N_LIM; i++) begin
                if (!found && s.limEn[i] && !e.lowF[i] && !e.uppF[i]) begin
                    e.pat = s.passPat[i];
                    found = 1'b1;
                end
            end
        end
        e.pat = e.pat & m;
        return e;
    endfunction

    ltb_feed u_feed (
        .clock      (clock),
        .rst_b      (rst_b),
        .rdg        (rdg),
        .feedSel    (ltb_feed_e'(s_q.ctrl[CF_FEED +: 2])),
        .nullEn     (s_q.ctrl[CF_NULL]),
        .nullOffset (s_q.offs),
        .feed       (feed)
    );

    ltb_mem #(.W(32), .DEPTH(BUF_DEPTH)) u_mem (
        .clock (clock),
        .rst_b (rst_b),
        .we    (memWe),
        .wAddr (memAddr),
        .wData (feed.calc),
        .rAddr (s_q.bufPtr),
        .rData (memData)
    );

    // shared decode of events and the evaluation
    assign curMask = patMask(s_q.ctrl[CF_WID +: 2]);
    assign anyEn   = s_q.ctrl[CF_LIM1] | (|s_q.limEn);
    assign ev      = evaluate(s_q, feed, curMask);
    assign wrFire  = s_q.awPend && s_q.wPend && !s_q.bValid;
    assign clrEv   = (wrFire && s_q.awAddr == R_CMD && s_q.wData[CMD_CLR])
                   || (seqStart && s_q.ctrl[CF_AUTO]);
    assign memWe   = feed.valid && anyEn && (clrEv || s_q.count < CW'(BUF_DEPTH));
    assign memAddr = clrEv ? '0 : s_q.count[PW-1:0];

    // next state: clear, then hardware results, then software writes
    always_comb begin
        logic [31:0] wv;
        logic [3:0]  ti;
        wv = wmerge(regRead(s_q, s_q.awAddr, memData), s_q.wData, s_q.wStrb);
        ti = tIdx(s_q.awAddr);
        s_d = s_q;
        if (clrEv) begin
            s_d.failFlg = '0;
            s_d.evt     = '0;
            s_d.outPat  = s_q.defPat & curMask;
            s_d.pendV   = 1'b0;
            s_d.count   = '0;
        end
        if (feed.valid && s_q.acqPend) begin
            s_d.offs    = feed.raw;
            s_d.acqPend = 1'b0;
        end
        if (feed.valid && anyEn) begin
            s_d.latest  = feed.calc;
            s_d.failFlg = s_d.failFlg | {ev.lowF | ev.uppF, ev.cmpFail};
            s_d.evt[N_LIM-1:0]       = s_d.evt[N_LIM-1:0] | ev.lowF;
            s_d.evt[EVT_UPP +: N_LIM] = s_d.evt[EVT_UPP +: N_LIM] | ev.uppF;
            if (memWe) begin
                s_d.count = s_d.count + CW'(1);
            end
            if (s_q.ctrl[CF_END]) begin
                s_d.pendPat = ev.pat;
                s_d.pendV   = 1'b1;
            end else begin
                s_d.outPat = ev.pat;
            end
        end
        if (seqEnd && s_d.pendV) begin
            s_d.outPat = s_d.pendPat;
            s_d.pendV  = 1'b0;
        end
        // write channel: address and data taken in either order
        if (axiReq.awvalid && !s_q.awPend && !s_q.bValid) begin
            s_d.awPend = 1'b1;
            s_d.awAddr = {axiReq.awaddr[AW-1:2], 2'b00};
        end
        if (axiReq.wvalid && !s_q.wPend && !s_q.bValid) begin
            s_d.wPend = 1'b1;
            s_d.wData = axiReq.wdata;
            s_d.wStrb = axiReq.wstrb;
        end
        if (s_q.bValid && axiReq.bready) begin
            s_d.bValid = 1'b0;
        end
        if (wrFire) begin
            s_d.awPend = 1'b0;
            s_d.wPend  = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bResp  = mapped(s_q.awAddr) ? RESP_OK : RESP_ERR;
            unique case (s_q.awAddr)
                R_CTRL:   s_d.ctrl   = wv;
                R_OFFS:   s_d.offs   = wv;
                R_LIMEN:  s_d.limEn  = wv[N_LIM-1:0];
                R_GPAT:   s_d.gPat   = wv;
                R_CMPPAT: s_d.cmpPat = wv[15:0];
                R_DEFPAT: s_d.defPat = wv[15:0];
                R_BUFPTR: s_d.bufPtr = wv[PW-1:0];
                R_CMD: begin
                    if (s_q.wData[CMD_ACQ]) begin
                        s_d.acqPend = 1'b1;
                    end
                end
                default: begin
                    if (tHit(s_q.awAddr)) begin
                        unique case (s_q.awAddr[3:2])
                            T_LOW:  s_d.lowLim[ti]  = wv;
                            T_UPP:  s_d.uppLim[ti]  = wv;
                            T_FPAT: s_d.failPat[ti] = wv;
                            T_PPAT: s_d.passPat[ti] = wv[15:0];
                        endcase
                    end
                end
            endcase
        end
        // read channel: one wait cycle, data from a register
        if (axiReq.arvalid && !s_q.arPend && !s_q.rValid) begin
            s_d.arPend = 1'b1;
            s_d.arAddr = {axiReq.araddr[AW-1:2], 2'b00};
        end
        if (s_q.arPend) begin
            s_d.arPend = 1'b0;
            s_d.rValid = 1'b1;
            s_d.rData  = regRead(s_q, s_q.arAddr, memData);
            s_d.rResp  = mapped(s_q.arAddr) ? RESP_OK : RESP_ERR;
        end
        if (s_q.rValid && axiReq.rready) begin
            s_d.rValid = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= S_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // bus answers and output lines
    assign axiRsp.awready = !s_q.awPend && !s_q.bValid;
    assign axiRsp.wready  = !s_q.wPend && !s_q.bValid;
    assign axiRsp.bvalid  = s_q.bValid;
    assign axiRsp.bresp   = s_q.bResp;
    assign axiRsp.arready = !s_q.arPend && !s_q.rValid;
    assign axiRsp.rvalid  = s_q.rValid;
    assign axiRsp.rdata   = s_q.rData;
    assign axiRsp.rresp   = s_q.rResp;
    assign digOut         = s_q.outPat[OUT_W-1:0];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_imm_update: assert property (feed.valid && anyEn && !s_q.ctrl[CF_END] && !s_q.pendV
        |=> s_q.outPat == $past(ev.pat)) else $error("immediate pattern not driven");
    a_end_hold: assert property (s_q.ctrl[CF_END] && !seqEnd && !clrEv |=> $stable(s_q.outPat))
        else $error("output moved before end");
    a_cmp_first: assert property (ev.cmpFail |-> ev.pat == (s_q.cmpPat & curMask))
        else $error("compliance pattern not first");
    a_grade_pass: assert property (!s_q.ctrl[CF_SORT] && !ev.anyFail
        |-> ev.pat == (s_q.gPat[15:0] & curMask)) else $error("grading pass wrong");
    a_sort_none: assert property (s_q.ctrl[CF_SORT] && !ev.cmpFail && s_q.limEn != '0
        && (s_q.limEn & ~(ev.lowF | ev.uppF)) == '0
        |-> ev.pat == (s_q.gPat[31:16] & curMask)) else $error("sorting fail wrong");
    a_flag_sticky: assert property (!$past(clrEv)
        |-> ($past(s_q.failFlg) & ~s_q.failFlg) == '0) else $error("flag lost");
    a_clear_out: assert property (clrEv && !(feed.valid && anyEn) && !seqEnd
        |=> s_q.failFlg == '0 && s_q.outPat == $past(s_q.defPat & curMask))
        else $error("clear incomplete");
    a_skip_off: assert property (feed.valid && !anyEn && !clrEv && !seqEnd
        |=> $stable(s_q.outPat) && $stable(s_q.failFlg)) else $error("idle test acted");
    a_buf_gate: assert property (memWe |-> feed.valid && anyEn)
        else $error("reading stored while tests off");
    a_latest_rdg: assert property (feed.valid && anyEn |=> s_q.latest == $past(feed.calc))
        else $error("latest reading stale");
    a_acq_take: assert property (feed.valid && s_q.acqPend && !wrFire
        |=> s_q.offs == $past(feed.raw) && !s_q.acqPend) else $error("offset not taken");

    c_sort_band: cover property (feed.valid && s_q.ctrl[CF_SORT] && !ev.cmpFail
        && (s_q.limEn & ~(ev.lowF | ev.uppF)) != '0);
    c_grade_fail: cover property (feed.valid && !s_q.ctrl[CF_SORT] && |ev.lowF);
    c_end_apply: cover property (seqEnd && s_q.pendV);
    c_acquire: cover property (feed.valid && s_q.acqPend);
endmodule

// [testbench/ltb_handler.sv]
// handler model: latches the output lines once per clock as its bin choice
`timescale 1ns/10ps
module ltb_handler
    import ltb_pkg::*;
#(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_b,
    // lines from the block and latched bin
    input  wire logic [W-1:0] lines,
    output logic      [W-1:0] binQ
);
    // line n carries bit n-1, high means one
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) binQ <= '0;
        else binQ <= lines;
    end
endmodule

// [testbench/testbench.sv]
// testbench of the limit-test binning core
`timescale 1ns/10ps
module testbench
    import ltb_pkg::*;
;
    logic         clock = 0;
    logic         rst_b = 0;
    ltb_axi_req_s req   = '0;
    ltb_axi_rsp_s rsp;
    ltb_rdg_s     rdg   = '0;
    logic [15:0]  digOut;
    logic [15:0]  binQ;
    logic [31:0]  rv;
    logic [1:0]   rr;
    int           n_mismatch = 0;
    int           cmp_count  = 0;
    logic         seqStart   = 0;
    logic         seqEnd     = 0;
    ltb_core #(.OUT_W(16), .BUF_DEPTH(64)) DUT (.clock(clock), .rst_b(rst_b), .axiReq(req),
        .axiRsp(rsp), .rdg(rdg), .seqStart(seqStart), .seqEnd(seqEnd), .digOut(digOut));
    ltb_handler #(.W(16)) hnd (.clock(clock), .rst_b(rst_b), .lines(digOut), .binQ(binQ));
    always #12.5 clock = ~clock;
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // bus write, waits for the response however long it takes, keeps bresp
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1;
        req.wvalid <= 1;
        do begin
            @(posedge clock);
            if (req.awvalid && rsp.awready) req.awvalid <= 0;
            if (req.wvalid && rsp.wready) req.wvalid <= 0;
        end while (!rsp.bvalid);
        rr = rsp.bresp;
    endtask
    // bus read, takes data and response at the answer edge
    task automatic rd(input logic [7:0] a);
        req.araddr <= a;
        req.arvalid <= 1;
        do begin
            @(posedge clock);
            if (req.arvalid && rsp.arready) req.arvalid <= 0;
        end while (!rsp.rvalid);
        rv = rsp.rdata;
        rr = rsp.rresp;
    endtask
    // one reading, sources apart so that the choice shows, then settle
    task automatic rdgIn(input logic [31:0] v);
        rdg.mathRes <= v + 32'h0000_0010;
        rdg.volt <= v;
        rdg.curr <= v + 32'h0000_0020;
        rdg.res <= v + 32'h0000_0030;
        rdg.valid <= 1;
        @(posedge clock);
        rdg.valid <= 0;
        repeat (3) @(posedge clock);
    endtask
    task automatic stop_test();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        stop_test();
    end
    // reset values of the limits, bus answers for mapped and unmapped slots
    task automatic t_defaults();
        rd(T_BASE);       chk(rv, 32'hFFFF_FFFF);
        rd(T_BASE + 4);   chk(rv, 32'h0000_0001);
        rd(8'hFC);        chk(rr, RESP_ERR);
        wr(8'hFC, 1);     chk(rr, RESP_ERR);
        wr(R_DEFPAT, 32'h0000_0002); chk(rr, RESP_OK);
    endtask
    // null offset, acquire and source choice in 4-bit and 3-bit mode
    task automatic t_offset();
        wr(R_OFFS, 32'h0000_0004);
        wr(R_CTRL, 32'h0000_0085);
        rdgIn(5);         chk(binQ, 16'h0009);
        rd(R_LATEST);     chk(rv, 32'h0000_0001);
        wr(R_CMD, 32'h0000_0002);
        rdgIn(7);         chk(binQ, 16'h0005);
        rd(R_OFFS);       chk(rv, 32'h0000_0007);
        wr(R_CTRL, 32'h0000_0004);
        rdgIn(32'hFFFF_FFF7); chk(binQ, 16'h0001);
        rd(R_LATEST);     chk(rv, 32'h0000_0000);
    endtask
    // sorting: first passing band, compliance pattern, global fail
    task automatic t_sorting();
        wr(R_CTRL, 32'h0000_0289);
        wr(R_CMPPAT, 32'h0000_000C);
        wr(R_GPAT, 32'h000E_0009);
        wr(T_BASE + 8'h0C, 32'h0000_0006);
        wr(T_BASE + 8'h10, 32'h0000_0000);
        wr(T_BASE + 8'h14, 32'h0000_0004);
        wr(T_BASE + 8'h1C, 32'h0000_0007);
        wr(R_LIMEN, 32'h0000_0003);
        rdgIn(0);         chk(binQ, 16'h0006);
        rdgIn(3);         chk(binQ, 16'h0007);
        rdgIn(9);         chk(binQ, 16'h000E);
        rdg.inCmp <= 1;
        rdgIn(0);         chk(binQ, 16'h000C);
        rdg.inCmp <= 0;
        rd(R_FLAGS);      chk(rv, 32'h0000_0007);
    endtask
    // end mode holds the pattern, auto-clear at start, storing gated
    task automatic t_end();
        wr(R_CTRL, 32'h0000_00B1);
        wr(R_LIMEN, 32'h0000_0001);
        rdgIn(5);         chk(binQ, 16'h000C);
        seqEnd <= 1;
        @(posedge clock);
        seqEnd <= 0;
        repeat (2) @(posedge clock);
        chk(binQ, 16'h0005);
        seqStart <= 1;
        @(posedge clock);
        seqStart <= 0;
        repeat (2) @(posedge clock);
        chk(binQ, 16'h0002);
        rd(R_FLAGS);      chk(rv, 32'h0000_0000);
        wr(R_LIMEN, 32'h0000_0000);
        rdgIn(1);         chk(binQ, 16'h0002);
        rd(R_COUNT);      chk(rv, 32'h0000_0000);
        wr(R_LIMEN, 32'h0000_0001);
        rdgIn(1);
        rd(R_COUNT);      chk(rv, 32'h0000_0001);
        rd(R_BUFDATA);    chk(rv, 32'h0000_0001);
    endtask
    // grading: first failure picks the pattern, flags stick until cleared
    task automatic t_grading();
        wr(R_CTRL, 32'h0000_0081);
        wr(T_BASE + 8, 32'h0005_0003);
        wr(R_GPAT, 32'h0000_0009);
        wr(R_LIMEN, 32'h0000_0001);
        rdgIn(5);         chk(binQ, 16'h0005);
        rd(R_FLAGS);      chk(rv, 32'h0000_0002);
        rdgIn(-2);        chk(binQ, 16'h0003);
        rd(R_EVT);        chk(rv, 32'h0001_0001);
        rdgIn(0);         chk(binQ, 16'h0009);
        rd(R_FLAGS);      chk(rv, 32'h0000_0002);
        wr(R_CMD, 32'h0000_0001);
        repeat (2) @(posedge clock);
        chk(binQ, 16'h0002);
        rd(R_FLAGS);      chk(rv, 32'h0000_0000);
    endtask
    initial begin
        req.bready <= 1;
        req.rready <= 1;
        repeat (8) @(posedge clock);
        rst_b <= 1;
        @(posedge clock);
        t_defaults();
        t_grading();
        t_offset();
        t_sorting();
        t_end();
        stop_test();
    end
endmodule
